// ===== verilog/pfg_map.vh
// Constants for the port F/G override and port register block
`ifndef PFG_MAP_VH
`define PFG_MAP_VH

// Geometry
`define PFG_W           8
`define PFG_NPORT       5
`define PFG_NPIN        40
`define PFG_G_UNUSED    3
`define PFG_PORT_A      0
`define PFG_PORT_B      1
`define PFG_PORT_C      2
`define PFG_PORT_F      3
`define PFG_PORT_G      4
`define PFG_IDX(p,b)    ((p)*`PFG_W+(b))
`define PFG_PIN_VALID   40'h1FFFFFFFFF
`define PFG_G_MASK      8'h1F
`define PFG_FULL_MASK   8'hFF

// Pin positions inside a port
`define PFG_TDI_BIT     7
`define PFG_TDO_BIT     6
`define PFG_TMS_BIT     5
`define PFG_TCK_BIT     4
`define PFG_F_UPPER_LO  4
`define PFG_OSCI_BIT    4
`define PFG_OSCO_BIT    3
`define PFG_ALE_BIT     2
`define PFG_RD_BIT      1
`define PFG_WR_BIT      0

// Register map: word index, byte address is four times index
`define PFG_REGS_PER_PORT 3
`define PFG_KIND_DATA   0
`define PFG_KIND_DIR    1
`define PFG_KIND_PIN    2
`define PFG_IDX_CTRL    7'h0F
`define PFG_IDX_DIDR    7'h10
`define PFG_IDX_HI      8
`define PFG_IDX_LO      2
`define PFG_IDX_W       7
`define PFG_UNMAP_LO    9
`define PFG_ALIGN_HI    1

// Control register fields
`define PFG_CTRL_AS     0
`define PFG_CTRL_EXTERNAL_CLOCK_SELECT  1
`define PFG_CTRL_SRE    2
`define PFG_CTRL_MASK   8'h07

// Reset values
`define PFG_RST_PINS    40'h0000000000
`define PFG_RST_BYTE    8'h00
`define PFG_RST_WORD    32'h00000000

// AHB-Lite encodings
`define PFG_HTRANS_ACT  1
`define PFG_HSIZE_WORD  3'h2
`define PFG_HRESP_OKAY  1'b0

`endif

// ===== verilog/pfg_sync.v
// Two-flop synchroniser for one pin level
`timescale 1ns/10ps
module pfg_sync (
  input  wire core_clk,  // System clock
  input  wire rst,       // Synchronous reset, high
  input  wire ce,        // Clock enable
  input  wire asyncIn,   // Level from a pad
  output wire syncOut    // Level in core domain
);

  reg metaQ;  // First stage, read only by second
  reg syncQ;  // Second stage

  // Two stages; reset value only hides start-up unknowns
  always @(posedge core_clk) begin
    if (rst) begin
      metaQ <= 1'b0;
      syncQ <= 1'b0;
    end else if (ce) begin
      metaQ <= asyncIn;
      syncQ <= metaQ;
    end
  end

  assign syncOut = syncQ;

endmodule

// ===== verilog/pfg_pin_cell.v
// One pin: override selection between port registers and functions
`timescale 1ns/10ps
module pfg_pin_cell (
  input  wire portData,  // Output data register bit
  input  wire portDir,   // Direction register bit
  input  wire pinLevel,  // Synchronised pad level
  input  wire pullup_override_enable,      // Pull-up override enable
  input  wire pullup_override_value,      // Pull-up override value
  input  wire direction_override_enable,      // Direction override enable
  input  wire direction_override_value,      // Direction override value
  input  wire out_value_override_enable,      // Output value override enable
  input  wire out_value_override_value,      // Output value override value
  input  wire input_enable_override_enable,     // Input enable override enable
  input  wire input_enable_override_value,     // Input enable override value
  output wire padOut,    // Value driven to pad
  output wire padOe,     // Pad driver enable, high drives
  output wire padPull,   // Pull-up enable
  output wire digIn      // Gated digital input
);

  wire normPull;  // Pull-up from registers: input with data one

  // Register path pull-up only applies to an input pin
  assign normPull = portData & ~portDir;

  // Each attribute takes its override when enabled
  assign padOe   = direction_override_enable ? direction_override_value : portDir;
  assign padOut  = out_value_override_enable ? out_value_override_value : portData;
  assign padPull = pullup_override_enable ? pullup_override_value : normPull;
  // Disabled input buffer reads as zero
  assign digIn   = pinLevel & (input_enable_override_enable ? input_enable_override_value : 1'b1);

endmodule

// ===== verilog/pfg_top.v
// Port F/G override logic with port registers on AHB-Lite
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "pfg_map.vh"
module pfg_top (
  input  wire        core_clk,          // System clock, 40 MHz
  input  wire        rst,               // Synchronous reset, high
  input  wire        ce,                // Clock enable, low freezes
  input  wire        hsel,              // AHB slave select
  input  wire [31:0] haddr,             // AHB address
  input  wire [1:0]  htrans,            // AHB transfer type
  input  wire        hwrite,            // AHB write
  input  wire [2:0]  hsize,             // AHB size
  input  wire [31:0] hwdata,            // AHB write data
  input  wire        hready,            // AHB bus ready in
  output wire        hreadyout,         // AHB slave ready
  output wire        hresp,             // AHB response, always OKAY
  output wire [31:0] hrdata,            // AHB read data
  input  wire [7:0]  paPin,             // Port A pad levels
  output wire [7:0]  paOut,             // Port A pad values
  output wire [7:0]  paOe,              // Port A driver enables
  output wire [7:0]  paPull,            // Port A pull-ups
  input  wire [7:0]  pbPin,             // Port B pad levels
  output wire [7:0]  pbOut,             // Port B pad values
  output wire [7:0]  pbOe,              // Port B driver enables
  output wire [7:0]  pbPull,            // Port B pull-ups
  input  wire [7:0]  pcPin,             // Port C pad levels
  output wire [7:0]  pcOut,             // Port C pad values
  output wire [7:0]  pcOe,              // Port C driver enables
  output wire [7:0]  pcPull,            // Port C pull-ups
  input  wire [7:0]  pfPin,             // Port F pad levels
  output wire [7:0]  pfOut,             // Port F pad values
  output wire [7:0]  pfOe,              // Port F driver enables
  output wire [7:0]  pfPull,            // Port F pull-ups
  input  wire [4:0]  pgPin,             // Port G pad levels
  output wire [4:0]  pgOut,             // Port G pad values
  output wire [4:0]  pgOe,              // Port G driver enables
  output wire [4:0]  pgPull,            // Port G pull-ups
  input  wire        testPortEnable,    // Test port enable level
  input  wire        instrShiftState,   // Test controller in instruction shift
  input  wire        dataShiftState,    // Test controller in data shift
  input  wire        testDataOut,       // Serial test data out
  output wire        testDataIn,        // Test data in to controller
  output wire        testModeSel,       // Test mode select to controller
  output wire        testClock,         // Test clock to controller
  input  wire        memAddrLatch,      // External memory address latch strobe
  input  wire        memReadStrobe,     // External memory read strobe
  input  wire        memWriteStrobe,    // External memory write strobe
  output wire        asyncClkSel,       // Timer oscillator select, to timer
  output wire        extClkSel,         // External clock select, to timer
  output wire        extMemEn,          // External memory enable, to memory unit
  output wire [7:0]  convDigitalDisable // Converter digital disable bits
);

  integer i;                                 // Loop index for combinational blocks
  integer p;                                 // Port index in loops
  genvar  g;                                 // Per-pin generate index

  // Register state
  reg  [`PFG_NPIN-1:0]  dataQ;               // Output data, all ports
  reg  [`PFG_NPIN-1:0]  dataD;               // Next output data
  reg  [`PFG_NPIN-1:0]  dirQ;                // Direction, all ports
  reg  [`PFG_NPIN-1:0]  dirD;                // Next direction
  reg  [`PFG_W-1:0]     ctrlQ;               // Oscillator and memory select bits
  reg  [`PFG_W-1:0]     ctrlD;               // Next control
  reg  [`PFG_W-1:0]     didrQ;               // Converter digital disable
  reg  [`PFG_W-1:0]     didrD;               // Next digital disable

  // Bus state
  reg                   wrPendQ;             // Write data phase pending
  reg                   rdWaitQ;             // Read wait state
  reg  [`PFG_IDX_W-1:0] idxQ;                // Word index of data phase
  reg                   mapQ;                // Address of data phase mapped
  reg  [31:0]           rdataQ;              // Read data register
  reg  [31:0]           rdataD;              // Read data mux
  wire                  busTake;             // Address phase accepted
  wire                  mapOk;               // Address is mapped and aligned

  // Override vectors, one bit per pin
  reg  [`PFG_NPIN-1:0]  ovPuOe;              // Pull-up override enables
  reg  [`PFG_NPIN-1:0]  ovPuOv;              // Pull-up override values
  reg  [`PFG_NPIN-1:0]  ovDdOe;              // Direction override enables
  reg  [`PFG_NPIN-1:0]  ovDdOv;              // Direction override values
  reg  [`PFG_NPIN-1:0]  ovPvOe;              // Output value override enables
  reg  [`PFG_NPIN-1:0]  ovPvOv;              // Output value override values
  reg  [`PFG_NPIN-1:0]  ovPtOe;              // Pin toggle override enables
  reg  [`PFG_NPIN-1:0]  ovDieOe;             // Input enable override enables
  reg  [`PFG_NPIN-1:0]  ovDieOv;             // Input enable override values

  // Pin side vectors
  wire [`PFG_NPIN-1:0]  pinRaw;              // Pad levels, flattened
  wire [`PFG_NPIN-1:0]  pinSync;             // Synchronised pad levels
  wire [`PFG_NPIN-1:0]  digIn;               // Gated digital inputs
  wire [`PFG_NPIN-1:0]  padOut;              // Pad values
  wire [`PFG_NPIN-1:0]  padOe;               // Pad enables
  wire [`PFG_NPIN-1:0]  padPull;             // Pad pull-ups
  wire [`PFG_NPIN-1:0]  padOutM;             // Pad values, absent pins zero
  wire [`PFG_NPIN-1:0]  padOeM;              // Pad enables, absent pins zero
  wire [`PFG_NPIN-1:0]  padPullM;            // Pad pull-ups, absent pins zero

  // Control decode
  wire                  asSel;               // Timer oscillator select
  wire                  exSel;               // External clock select
  wire                  sreSel;              // External memory enable

  assign asSel  = ctrlQ[`PFG_CTRL_AS];
  assign exSel  = ctrlQ[`PFG_CTRL_EXTERNAL_CLOCK_SELECT];
  assign sreSel = ctrlQ[`PFG_CTRL_SRE];

  // Port mask: port G has five pins only
  function [`PFG_W-1:0] portMask;
    input integer port;
    begin
      portMask = (port == `PFG_PORT_G) ? `PFG_G_MASK : `PFG_FULL_MASK;
    end
  endfunction

  // Flatten pad levels, absent G pins tied low
  assign pinRaw = {{`PFG_G_UNUSED{1'b0}}, pgPin, pfPin, pcPin, pbPin, paPin};

  // Address phase accept and map check
  assign busTake = ce & hsel & hready & htrans[`PFG_HTRANS_ACT];
  assign mapOk   = (haddr[31:`PFG_UNMAP_LO] == 23'h000000) && (haddr[`PFG_ALIGN_HI:0] == 2'h0) &&
                   (haddr[`PFG_IDX_HI:`PFG_IDX_LO] <= `PFG_IDX_DIDR) && (hsize <= `PFG_HSIZE_WORD);

  // Bus phase tracking: writes land one edge after address, reads wait one cycle
  always @(posedge core_clk) begin
    if (rst) begin
      wrPendQ <= 1'b0;
      rdWaitQ <= 1'b0;
      idxQ    <= 7'h00;
      mapQ    <= 1'b0;
    end else if (ce) begin
      wrPendQ <= busTake & hwrite;
      rdWaitQ <= busTake & ~hwrite;
      if (busTake) begin
        // Latch address for data phase
        idxQ <= haddr[`PFG_IDX_HI:`PFG_IDX_LO];
        mapQ <= mapOk;
      end
    end
  end

  // Read ready: one wait state; writes never stall
  assign hreadyout = ~rdWaitQ;
  assign hresp     = `PFG_HRESP_OKAY;
  assign hrdata    = rdataQ;

  // Override table for ports F and G; A, B, C have none
  always @* begin
    ovPuOe  = `PFG_RST_PINS;
    ovPuOv  = `PFG_RST_PINS;
    ovDdOe  = `PFG_RST_PINS;
    ovDdOv  = `PFG_RST_PINS;
    ovPvOe  = `PFG_RST_PINS;
    ovPvOv  = `PFG_RST_PINS;
    ovPtOe  = `PFG_RST_PINS;
    ovDieOe = `PFG_RST_PINS;
    ovDieOv = `PFG_RST_PINS;
    // Upper port F: test port takes pull, direction, value
    for (i = `PFG_F_UPPER_LO; i < `PFG_W; i = i + 1) begin
      ovPuOe[`PFG_IDX(`PFG_PORT_F, i)]  = testPortEnable;
      ovPuOv[`PFG_IDX(`PFG_PORT_F, i)]  = testPortEnable;
      ovDdOe[`PFG_IDX(`PFG_PORT_F, i)]  = testPortEnable;
      ovPvOe[`PFG_IDX(`PFG_PORT_F, i)]  = testPortEnable;
      ovDieOe[`PFG_IDX(`PFG_PORT_F, i)] = testPortEnable | didrQ[i];
      ovDieOv[`PFG_IDX(`PFG_PORT_F, i)] = testPortEnable;
    end
    // Test data out pin drives only while shifting
    ovDdOv[`PFG_IDX(`PFG_PORT_F, `PFG_TDO_BIT)]  = instrShiftState | dataShiftState;
    ovPvOv[`PFG_IDX(`PFG_PORT_F, `PFG_TDO_BIT)]  = testDataOut;
    ovDieOv[`PFG_IDX(`PFG_PORT_F, `PFG_TDO_BIT)] = 1'b0;
    // Lower port F: converter disable only
    for (i = 0; i < `PFG_F_UPPER_LO; i = i + 1) begin
      ovDieOe[`PFG_IDX(`PFG_PORT_F, i)] = didrQ[i];
    end
    // G4: oscillator amplifier input
    ovPuOe[`PFG_IDX(`PFG_PORT_G, `PFG_OSCI_BIT)]  = asSel;
    ovDdOe[`PFG_IDX(`PFG_PORT_G, `PFG_OSCI_BIT)]  = asSel;
    ovDieOe[`PFG_IDX(`PFG_PORT_G, `PFG_OSCI_BIT)] = asSel;
    ovDieOv[`PFG_IDX(`PFG_PORT_G, `PFG_OSCI_BIT)] = exSel;
    // G3: oscillator amplifier output
    ovPuOe[`PFG_IDX(`PFG_PORT_G, `PFG_OSCO_BIT)]  = asSel & exSel;
    ovDdOe[`PFG_IDX(`PFG_PORT_G, `PFG_OSCO_BIT)]  = asSel & exSel;
    ovDieOe[`PFG_IDX(`PFG_PORT_G, `PFG_OSCO_BIT)] = asSel;
    // G2..G0: external memory strobes, outputs without pull-up
    for (i = `PFG_WR_BIT; i <= `PFG_ALE_BIT; i = i + 1) begin
      ovPuOe[`PFG_IDX(`PFG_PORT_G, i)] = sreSel;
      ovDdOe[`PFG_IDX(`PFG_PORT_G, i)] = sreSel;
      ovDdOv[`PFG_IDX(`PFG_PORT_G, i)] = 1'b1;
      ovPvOe[`PFG_IDX(`PFG_PORT_G, i)] = sreSel;
    end
    ovPvOv[`PFG_IDX(`PFG_PORT_G, `PFG_ALE_BIT)] = memAddrLatch;
    ovPvOv[`PFG_IDX(`PFG_PORT_G, `PFG_RD_BIT)]  = memReadStrobe;
    ovPvOv[`PFG_IDX(`PFG_PORT_G, `PFG_WR_BIT)]  = memWriteStrobe;
  end

  // Per-pin synchroniser and override cell
  generate
    for (g = 0; g < `PFG_NPIN; g = g + 1) begin : gPin
      pfg_sync uSync (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .asyncIn  (pinRaw[g]),
        .syncOut  (pinSync[g])
      );
      pfg_pin_cell uCell (
        .portData (dataQ[g]),
        .portDir  (dirQ[g]),
        .pinLevel (pinSync[g]),
        .pullup_override_enable     (ovPuOe[g]),
        .pullup_override_value     (ovPuOv[g]),
        .direction_override_enable     (ovDdOe[g]),
        .direction_override_value     (ovDdOv[g]),
        .out_value_override_enable     (ovPvOe[g]),
        .out_value_override_value     (ovPvOv[g]),
        .input_enable_override_enable    (ovDieOe[g]),
        .input_enable_override_value    (ovDieOv[g]),
        .padOut   (padOut[g]),
        .padOe    (padOe[g]),
        .padPull  (padPull[g]),
        .digIn    (digIn[g])
      );
    end
  endgenerate

  // Absent G pins never drive
  assign padOutM  = padOut & `PFG_PIN_VALID;
  assign padOeM   = padOe & `PFG_PIN_VALID;
  assign padPullM = padPull & `PFG_PIN_VALID;

  // Pad outputs per port
  assign paOut  = padOutM[`PFG_IDX(`PFG_PORT_A, 0) +: `PFG_W];
  assign paOe   = padOeM[`PFG_IDX(`PFG_PORT_A, 0) +: `PFG_W];
  assign paPull = padPullM[`PFG_IDX(`PFG_PORT_A, 0) +: `PFG_W];
  assign pbOut  = padOutM[`PFG_IDX(`PFG_PORT_B, 0) +: `PFG_W];
  assign pbOe   = padOeM[`PFG_IDX(`PFG_PORT_B, 0) +: `PFG_W];
  assign pbPull = padPullM[`PFG_IDX(`PFG_PORT_B, 0) +: `PFG_W];
  assign pcOut  = padOutM[`PFG_IDX(`PFG_PORT_C, 0) +: `PFG_W];
  assign pcOe   = padOeM[`PFG_IDX(`PFG_PORT_C, 0) +: `PFG_W];
  assign pcPull = padPullM[`PFG_IDX(`PFG_PORT_C, 0) +: `PFG_W];
  assign pfOut  = padOutM[`PFG_IDX(`PFG_PORT_F, 0) +: `PFG_W];
  assign pfOe   = padOeM[`PFG_IDX(`PFG_PORT_F, 0) +: `PFG_W];
  assign pfPull = padPullM[`PFG_IDX(`PFG_PORT_F, 0) +: `PFG_W];
  assign pgOut  = padOutM[`PFG_IDX(`PFG_PORT_G, 0) +: 5];
  assign pgOe   = padOeM[`PFG_IDX(`PFG_PORT_G, 0) +: 5];
  assign pgPull = padPullM[`PFG_IDX(`PFG_PORT_G, 0) +: 5];

  // Digital inputs to the test controller
  assign testDataIn  = digIn[`PFG_IDX(`PFG_PORT_F, `PFG_TDI_BIT)];
  assign testModeSel = digIn[`PFG_IDX(`PFG_PORT_F, `PFG_TMS_BIT)];
  assign testClock   = digIn[`PFG_IDX(`PFG_PORT_F, `PFG_TCK_BIT)];

  // Control bits to peripherals
  assign asyncClkSel        = asSel;
  assign extClkSel          = exSel;
  assign extMemEn           = sreSel;
  assign convDigitalDisable = didrQ;

  // Next register values: data phase write, pin-register toggles
  always @* begin
    dataD = dataQ;
    dirD  = dirQ;
    ctrlD = ctrlQ;
    didrD = didrQ;
    if (wrPendQ && mapQ) begin
      for (p = 0; p < `PFG_NPORT; p = p + 1) begin
        // Output data register write
        if (idxQ == p * `PFG_REGS_PER_PORT + `PFG_KIND_DATA) begin
          dataD[p*`PFG_W +: `PFG_W] = hwdata[`PFG_W-1:0] & portMask(p);
        end
        // Direction register write
        if (idxQ == p * `PFG_REGS_PER_PORT + `PFG_KIND_DIR) begin
          dirD[p*`PFG_W +: `PFG_W] = hwdata[`PFG_W-1:0] & portMask(p);
        end
        // Writing ones to the pin register flips the data bits
        if (idxQ == p * `PFG_REGS_PER_PORT + `PFG_KIND_PIN) begin
          dataD[p*`PFG_W +: `PFG_W] = dataQ[p*`PFG_W +: `PFG_W] ^ (hwdata[`PFG_W-1:0] & portMask(p));
        end
      end
      // Own control registers
      if (idxQ == `PFG_IDX_CTRL) begin
        ctrlD = hwdata[`PFG_W-1:0] & `PFG_CTRL_MASK;
      end
      if (idxQ == `PFG_IDX_DIDR) begin
        didrD = hwdata[`PFG_W-1:0];
      end
    end
    // Toggle override flips data; held at zero on F and G
    dataD = dataD ^ ovPtOe;
  end

  // Register storage
  always @(posedge core_clk) begin
    if (rst) begin
      dataQ <= `PFG_RST_PINS;
      dirQ  <= `PFG_RST_PINS;
      ctrlQ <= `PFG_RST_BYTE;
      didrQ <= `PFG_RST_BYTE;
    end else if (ce) begin
      dataQ <= dataD;
      dirQ  <= dirD;
      ctrlQ <= ctrlD;
      didrQ <= didrD;
    end
  end

  // Read mux; pin register shows gated synchronised pads
  always @* begin
    rdataD = `PFG_RST_WORD;
    if (mapQ) begin
      for (p = 0; p < `PFG_NPORT; p = p + 1) begin
        if (idxQ == p * `PFG_REGS_PER_PORT + `PFG_KIND_DATA) begin
          rdataD[`PFG_W-1:0] = dataQ[p*`PFG_W +: `PFG_W];
        end
        if (idxQ == p * `PFG_REGS_PER_PORT + `PFG_KIND_DIR) begin
          rdataD[`PFG_W-1:0] = dirQ[p*`PFG_W +: `PFG_W];
        end
        if (idxQ == p * `PFG_REGS_PER_PORT + `PFG_KIND_PIN) begin
          rdataD[`PFG_W-1:0] = digIn[p*`PFG_W +: `PFG_W] & portMask(p);
        end
      end
      if (idxQ == `PFG_IDX_CTRL) begin
        rdataD[`PFG_W-1:0] = ctrlQ;
      end
      if (idxQ == `PFG_IDX_DIDR) begin
        rdataD[`PFG_W-1:0] = didrQ;
      end
    end
  end

  // Read data loads in the wait cycle, after any earlier write landed
  always @(posedge core_clk) begin
    if (rst) begin
      rdataQ <= `PFG_RST_WORD;
    end else if (ce && rdWaitQ) begin
      rdataQ <= rdataD;
    end
  end

endmodule

// ===== verif/pfg_pad_model.sv
// Pad model for one port: device drivers, pull-ups and an outside driver
`timescale 1ns/10ps
module pfg_pad_model #(
  parameter W = 8                  // Pin count
) (
  input  wire         core_clk,    // Clock for the floating pattern
  input  wire [W-1:0] out,         // Device output values
  input  wire [W-1:0] oe,          // Device driver enables
  input  wire [W-1:0] pull,        // Device pull-up enables
  input  wire [W-1:0] extEn,       // Outside driver enables
  input  wire [W-1:0] extVal,      // Outside driver values
  output wire [W-1:0] pin          // Resolved pad levels
);
  reg [W-1:0] float_q = {W{1'b0}}; // Level of undriven, unpulled pads
  // Undriven, unpulled pads change every cycle so no stale level can be read
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end
  // Device driver first, then outside driver, then pull-up or float
  assign pin = (oe & out) | (~oe & extEn & extVal) | (~oe & ~extEn & (pull | float_q));
endmodule

// ===== verif/pfg_top_assertions.sv
// Concurrent checks on the pin override outputs of the port block
`timescale 1ns/10ps
module pfg_top_assertions (
  input wire       core_clk,        // System clock
  input wire       rst,             // Synchronous reset, high
  input wire       testPortEnable,  // Test port enable
  input wire       instrShiftState, // Instruction shift state
  input wire       dataShiftState,  // Data shift state
  input wire       testDataOut,     // Serial test data out
  input wire [7:0] pfOut,           // Port F pad values
  input wire [7:0] pfOe,            // Port F driver enables
  input wire [7:0] pfPull,          // Port F pull-ups
  input wire [4:0] pgOut,           // Port G pad values
  input wire [4:0] pgOe,            // Port G driver enables
  input wire [4:0] pgPull,          // Port G pull-ups
  input wire       memAddrLatch,    // Address latch strobe
  input wire       memReadStrobe,   // Read strobe
  input wire       memWriteStrobe,  // Write strobe
  input wire       asyncClkSel,     // Timer oscillator select
  input wire       extClkSel,       // External clock select
  input wire       extMemEn         // External memory enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_tap_pull: assert property (testPortEnable |-> pfPull[7:4] == 4'hF) else $error("tap pull-ups off");
  a_tap_inputs: assert property (testPortEnable |-> pfOe[7] == 1'b0 && pfOe[5:4] == 2'h0)
    else $error("tap input pin driven");
  a_tap_low: assert property (testPortEnable |-> pfOut[7] == 1'b0 && pfOut[5:4] == 2'h0)
    else $error("tap pin value not low");
  a_tdo_drive: assert property (testPortEnable |-> pfOe[6] == (instrShiftState || dataShiftState)
    && pfOut[6] == testDataOut) else $error("test data out pin wrong");
  a_osc_in: assert property (asyncClkSel |-> !pgOe[4] && !pgPull[4]) else $error("oscillator input used");
  a_osc_out: assert property (asyncClkSel && extClkSel |-> !pgOe[3] && !pgPull[3])
    else $error("oscillator output used");
  a_mem_dir: assert property (extMemEn |-> pgOe[2:0] == 3'h7 && pgPull[2:0] == 3'h0)
    else $error("strobe pins not outputs");
  a_mem_strobe: assert property (extMemEn |-> pgOut[2:0] == {memAddrLatch, memReadStrobe, memWriteStrobe})
    else $error("strobe values wrong");
endmodule
bind pfg_top pfg_top_assertions u_pfg_top_assertions (.*);

// ===== verif/testbench.sv
// Self-checking bench for the port F/G override block
`timescale 1ns/10ps
module testbench;
  localparam [31:0] F_DATA = 32'h24, F_PIN = 32'h2C, G_DATA = 32'h30, G_DIR = 32'h34;
  localparam [31:0] G_PIN = 32'h38, CTRL = 32'h3C, DIS_REG = 32'h40;
  reg         core_clk, rst, ce, hsel, hwrite, testPortEnable, instrShiftState, dataShiftState;
  reg         testDataOut, memAddrLatch, memReadStrobe, memWriteStrobe;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [31:0] haddr, hwdata, rdv;
  reg  [4:0]  pgEn;
  wire        hreadyout, hresp, testDataIn, testModeSel, testClock, asyncClkSel, extClkSel, extMemEn;
  wire [31:0] hrdata;
  wire [7:0]  paOut, paOe, paPull, pbOut, pbOe, pbPull, pcOut, pcOe, pcPull, pfOut, pfOe, pfPull, pfPin;
  wire [7:0]  convDigitalDisable;
  wire [4:0]  pgOut, pgOe, pgPull, pgPin;
  integer     failures = 0, compares = 0, i;
  pfg_top u_pfg_top (.*, .hready(hreadyout), .paPin(8'h00), .pbPin(pbOut), .pcPin(pcOut));
  pfg_pad_model #(.W(8)) u_pfg_pad_model (.core_clk(core_clk), .out(pfOut), .oe(pfOe), .pull(pfPull),
    .extEn(8'h00), .extVal(8'h00), .pin(pfPin));
  pfg_pad_model #(.W(5)) u_pfg_pad_model_g (.core_clk(core_clk), .out(pgOut), .oe(pgOe), .pull(pgPull),
    .extEn(pgEn), .extVal(pgEn), .pin(pgPin));
  // Clock, 25 ns period
  always #12.5 core_clk = ~core_clk;
  task wrap_up;
    begin
      $display("Counts: compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // Waits for the slave ready, bounded
  task wait_rdy;
    integer n;
    begin
      @(posedge core_clk);
      for (n = 0; hreadyout !== 1'b1 && n < 20; n = n + 1) @(posedge core_clk);
      if (hreadyout !== 1'b1) begin
        failures = failures + 1;
        wrap_up;
      end
    end
  endtask
  // One single word transfer, address then data phase
  task bus(input w, input [31:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      wait_rdy;
      rdv = hrdata;
    end
  endtask
  task rdc(input [31:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      cmp(rdv, {24'h000000, e});
    end
  endtask
  // Reset values, write and read back, unmapped place, normal pin control
  task t_regs;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        rdc(i * 12, 8'h00);
        rdc(i * 12 + 4, 8'h00);
        bus(1'b1, i * 12, 8'hA5 + i[7:0]);
        bus(1'b1, i * 12 + 4, 8'h3C + i[7:0]);
        rdc(i * 12, 8'hA5 + i[7:0]);
        rdc(i * 12 + 4, 8'h3C + i[7:0]);
      end
      bus(1'b1, 32'h44, 8'hFF);
      rdc(32'h44, 8'h00);
      cmp(paOe, 8'h3C);
      cmp({paOut, paPull}, 16'hA581);
      cmp({pbOe, pbPull, pcOe, pcPull}, 32'h3D823E81);
      rdc(32'h14, 8'hA6);
      $display("register test done");
    end
  endtask
  // Lower port F: only input gating by disable bits
  task t_fport;
    begin
      bus(1'b1, F_DATA + 4, 8'h0F);
      bus(1'b1, F_DATA, 8'hF3);
      bus(1'b1, DIS_REG, 8'h05);
      #1 cmp({pfOe, pfOut, pfPull, convDigitalDisable}, 32'h0FF3F005);
      rdc(F_PIN, 8'hF2);
      // Clock enable low: a write must not land
      ce <= 1'b0;
      bus(1'b1, F_DATA, 8'h00);
      ce <= 1'b1;
      rdc(F_DATA, 8'hF3);
      $display("port F test done");
    end
  endtask
  // Test port takes the upper four port F pins, also through a reset
  task t_tap;
    begin
      @(posedge core_clk);
      testPortEnable <= 1'b1;
      dataShiftState <= 1'b1;
      testDataOut <= 1'b1;
      #1 cmp({pfOe, pfOut, pfPull}, 24'h4F43F0);
      rdc(F_PIN, 8'hB2);
      cmp({testDataIn, testModeSel, testClock}, 3'h7);
      dataShiftState <= 1'b0;
      instrShiftState <= 1'b1;
      #1 cmp(pfOe, 8'h4F);
      @(posedge core_clk);
      instrShiftState <= 1'b0;
      #1 cmp(pfOe, 8'h0F);
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      #1 cmp(pfPull, 8'hF0);
      @(posedge core_clk);
      rst <= 1'b0;
      testPortEnable <= 1'b0;
      $display("test port test done");
    end
  endtask
  // Timer oscillator takes G4, then G3
  task t_osc;
    begin
      pgEn <= 5'h18;
      bus(1'b1, G_DATA, 8'hFF);
      bus(1'b1, G_DIR, 8'h08);
      rdc(G_DATA, 8'h1F);
      bus(1'b1, CTRL, 8'h01);
      #1 cmp({pgOe, pgPull}, 10'h107);
      rdc(G_PIN, 8'h07);
      bus(1'b1, CTRL, 8'h03);
      #1 cmp({pgOe, pgPull}, 10'h007);
      cmp({hresp, extMemEn, asyncClkSel, extClkSel}, 4'h3);
      rdc(G_PIN, 8'h17);
      $display("oscillator test done");
    end
  endtask
  // Memory strobes on G2..G0, every combination
  task t_mem;
    begin
      bus(1'b1, CTRL, 8'h04);
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge core_clk);
        {memAddrLatch, memReadStrobe, memWriteStrobe} <= i[2:0];
        #1 cmp(pgOut, {2'b11, i[2:0]});
      end
      cmp({pgOe, pgPull}, 10'h1F0);
      // Ones written to the pin register flip the data bits
      bus(1'b1, G_PIN, 8'hFF);
      rdc(G_DATA, 8'h00);
      $display("memory strobe test done");
    end
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {hsel, hwrite, testPortEnable, instrShiftState, dataShiftState, testDataOut} = 6'h00;
    {memAddrLatch, memReadStrobe, memWriteStrobe, htrans, pgEn} = 10'h000;
    {haddr, hwdata} = 64'h0;
    hsize = 3'h2;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_fport;
    t_tap;
    t_osc;
    t_mem;
    wrap_up;
  end
endmodule
